// ===== design/and_bit_pkg.sv
/*
  Shared constants for the AND and bit set/clear execution datapath.
  Assumes a 14-bit instruction word and a 7-bit file register address space.
*/
package and_bit_pkg;

  // ----------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_AND_LITERAL = 6'h39;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
  localparam logic [3:0] OPC_BIT_SET = 4'h5;
  localparam int OPC6_MSB = 13;
  localparam int OPC6_LSB = 8;
  localparam int OPC4_MSB = 13;
  localparam int OPC4_LSB = 10;
  localparam int DEST_BIT = 7;
  localparam int BIT_IDX_MSB = 9;
  localparam int BIT_IDX_LSB = 7;
  localparam int ADDR_MSB = 6;
  localparam int LIT_MSB = 7;

  // ----------------------------------------------------------------
  // Addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] TIMER_ZERO_COUNT_ADDR = 7'h01;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_AND_LITERAL = 3'b001,
    OP_AND_FILE = 3'b010,
    OP_BIT_CLEAR = 3'b011,
    OP_BIT_SET = 3'b100
  } op_t;

endpackage

// ===== design/exec_if.sv
/*
  Carrier between the execution top and its combinational ALU.
  Assumes both ends sit on the same clock.
*/
interface exec_if;
  logic [13:0] instr;
  logic [7:0] acc;
  logic [7:0] operand;
  and_bit_pkg::op_t op;
  logic [7:0] result;
  logic write_acc;
  logic write_file;
  logic update_zero;

  modport alu (input instr, acc, operand, output op, result, write_acc, write_file, update_zero);
  modport core (output instr, acc, operand, input op, result, write_acc, write_file, update_zero);
endinterface

// ===== design/and_bit_alu.sv
/*
  Decode and combinational result for the four supported instructions.
  Assumes the operand is already the correct source (latch or pins).
*/
module and_bit_alu (
  exec_if.alu bus
);
  logic [2:0] bit_idx;
  logic [7:0] mask;

  assign bit_idx = bus.instr[and_bit_pkg::BIT_IDX_MSB:and_bit_pkg::BIT_IDX_LSB];
  assign mask = 8'h01 << bit_idx;

  always_comb begin
    bus.op = and_bit_pkg::OP_NONE;
    bus.result = bus.operand;
    bus.write_acc = 1'b0;
    bus.write_file = 1'b0;
    bus.update_zero = 1'b0;
    if (bus.instr[and_bit_pkg::OPC6_MSB:and_bit_pkg::OPC6_LSB] == and_bit_pkg::OPC_AND_LITERAL) begin
      bus.op = and_bit_pkg::OP_AND_LITERAL;
      bus.result = bus.acc & bus.instr[and_bit_pkg::LIT_MSB:0];
      bus.write_acc = 1'b1;
      bus.update_zero = 1'b1;
    end else if (bus.instr[and_bit_pkg::OPC6_MSB:and_bit_pkg::OPC6_LSB]
                 == and_bit_pkg::OPC_AND_FILE) begin
      bus.op = and_bit_pkg::OP_AND_FILE;
      bus.result = bus.acc & bus.operand;
      bus.write_acc = ~bus.instr[and_bit_pkg::DEST_BIT];
      bus.write_file = bus.instr[and_bit_pkg::DEST_BIT];
      bus.update_zero = 1'b1;
    end else if (bus.instr[and_bit_pkg::OPC4_MSB:and_bit_pkg::OPC4_LSB]
                 == and_bit_pkg::OPC_BIT_CLEAR) begin
      bus.op = and_bit_pkg::OP_BIT_CLEAR;
      bus.result = bus.operand & ~mask;
      bus.write_file = 1'b1;
    end else if (bus.instr[and_bit_pkg::OPC4_MSB:and_bit_pkg::OPC4_LSB]
                 == and_bit_pkg::OPC_BIT_SET) begin
      bus.op = and_bit_pkg::OP_BIT_SET;
      bus.result = bus.operand | mask;
      bus.write_file = 1'b1;
    end
  end
endmodule // and_bit_alu

// ===== design/and_bit_exec.sv
/*
  Execution datapath for literal AND, file AND, bit clear and bit set.
  Assumes the core presents one instruction per cycle with its addressed
  file register value, the pin levels and a port flag, all on this clock.
*/
module and_bit_exec (
  input wire logic clock,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] pin_rdata,
  input wire logic file_is_port,
  input wire logic prescaler_on_timer,
  output logic [7:0] acc,
  output logic zero_flag,
  output logic file_we,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic prescaler_clear,
  output logic done
);
  exec_if bus ();
  logic [6:0] addr;
  logic writes_file;

  // ----------------------------------------------------------------
  // Operand selection and ALU
  // ----------------------------------------------------------------
  assign addr = instr[and_bit_pkg::ADDR_MSB:0];
  assign bus.instr = instr;
  assign bus.acc = acc;
  // Ports feed back the pin level so inputs are written as seen
  assign bus.operand = file_is_port ? pin_rdata : file_rdata;

  and_bit_alu u_alu (
    .bus(bus)
  );

  assign writes_file = instr_valid & bus.write_file;

  // ----------------------------------------------------------------
  // Accumulator and zero flag
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      acc <= and_bit_pkg::ACC_RESET;
    end else if (instr_valid && bus.write_acc) begin
      acc <= bus.result;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      zero_flag <= and_bit_pkg::ZERO_RESET;
    end else if (instr_valid && bus.update_zero) begin
      zero_flag <= (bus.result == 8'h00);
    end
  end

  // ----------------------------------------------------------------
  // File write port
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      file_we <= 1'b0;
      file_waddr <= 7'h00;
      file_wdata <= 8'h00;
    end else begin
      file_we <= writes_file;
      file_waddr <= addr;
      file_wdata <= bus.result;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prescaler_clear <= 1'b0;
    end else begin
      prescaler_clear <= writes_file && prescaler_on_timer
                         && (addr == and_bit_pkg::TIMER_ZERO_COUNT_ADDR);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= instr_valid && (bus.op != and_bit_pkg::OP_NONE);
    end
  end

  // ----------------------------------------------------------------
  // Checks: helper copies of the previous cycle
  // ----------------------------------------------------------------
  logic prev_ok;
  logic [13:0] prev_instr;
  logic [7:0] prev_operand;
  logic [7:0] prev_pin;
  logic [7:0] prev_acc;
  logic prev_zero;
  logic prev_port;
  logic prev_presc;
  and_bit_pkg::op_t prev_op;
  logic prev_run;
  logic [7:0] prev_latch;

  always_ff @(posedge clock) begin
    prev_ok <= ~rst & instr_valid;
    prev_instr <= instr;
    prev_operand <= bus.operand;
    prev_pin <= pin_rdata;
    prev_acc <= acc;
    prev_zero <= zero_flag;
    prev_port <= file_is_port;
    prev_presc <= prescaler_on_timer;
    prev_op <= bus.op;
    prev_run <= ~rst;
    prev_latch <= file_rdata;
  end

  chk_literal_and_acc: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_op == and_bit_pkg::OP_AND_LITERAL) |->
      (acc == (prev_acc & prev_instr[7:0])) && !file_we)
    else $error("literal AND result wrong");

  chk_file_and_acc: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_op == and_bit_pkg::OP_AND_FILE && !prev_instr[7]) |->
      (acc == (prev_acc & prev_operand)) && !file_we)
    else $error("file AND to accumulator wrong");

  chk_file_and_dest: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_op == and_bit_pkg::OP_AND_FILE && prev_instr[7]) |->
      file_we && file_wdata == (prev_acc & prev_operand) && acc == prev_acc
      && file_waddr == prev_instr[6:0])
    else $error("file AND write back wrong");

  chk_bit_clear_op: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_op == and_bit_pkg::OP_BIT_CLEAR) |->
      file_we && file_wdata == (prev_operand & ~(8'h01 << prev_instr[9:7]))
      && zero_flag == prev_zero)
    else $error("bit clear wrong");

  chk_bit_set_op: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_op == and_bit_pkg::OP_BIT_SET) |->
      file_we && file_wdata == (prev_operand | (8'h01 << prev_instr[9:7]))
      && zero_flag == prev_zero && acc == prev_acc)
    else $error("bit set wrong");

  chk_port_pin_source: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_port && prev_op == and_bit_pkg::OP_BIT_SET) |->
      file_wdata == (prev_pin | (8'h01 << prev_instr[9:7])))
    else $error("port read not from pins");

  chk_prescaler_clear: assert property (@(posedge clock) disable iff (rst)
    prescaler_clear == (file_we && prev_presc
      && file_waddr == and_bit_pkg::TIMER_ZERO_COUNT_ADDR))
    else $error("prescaler clear mismatch");

  chk_zero_flag_and: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && (prev_op == and_bit_pkg::OP_AND_FILE
      || prev_op == and_bit_pkg::OP_AND_LITERAL)) |->
      zero_flag == ((((prev_op == and_bit_pkg::OP_AND_LITERAL) ? prev_instr[7:0]
        : prev_operand) & prev_acc) == 8'h00))
    else $error("zero flag wrong");

  // ----------------------------------------------------------------
  // Checks: what must stay put, and where operands come from
  // ----------------------------------------------------------------
  // A missed hold would let an unrelated word corrupt the accumulator
  chk_reset_values: assert property (@(posedge clock) disable iff (rst)
    !prev_run |-> acc == and_bit_pkg::ACC_RESET && zero_flag == and_bit_pkg::ZERO_RESET
      && !file_we && !done && !prescaler_clear)
    else $error("outputs not at reset values");

  chk_idle_holds_state: assert property (@(posedge clock) disable iff (rst)
    (prev_run && !prev_ok) |->
      acc == prev_acc && zero_flag == prev_zero && !file_we && !done)
    else $error("idle cycle changed state");

  chk_unsupported_quiet: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_op == and_bit_pkg::OP_NONE) |->
      acc == prev_acc && zero_flag == prev_zero && !file_we && !done)
    else $error("unsupported word had an effect");

  chk_done_after_op: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_op != and_bit_pkg::OP_NONE) |-> done)
    else $error("done pulse missing");

  chk_acc_only_by_and: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_op != and_bit_pkg::OP_AND_LITERAL
      && !(prev_op == and_bit_pkg::OP_AND_FILE && !prev_instr[7])) |-> acc == prev_acc)
    else $error("accumulator changed without AND to it");

  chk_bit_clear_keeps: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_op == and_bit_pkg::OP_BIT_CLEAR) |->
      acc == prev_acc && file_waddr == prev_instr[6:0])
    else $error("bit clear touched accumulator or address");

  chk_bit_set_addr: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_op == and_bit_pkg::OP_BIT_SET) |-> file_waddr == prev_instr[6:0])
    else $error("bit set address wrong");

  chk_port_clear_source: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_port && prev_op == and_bit_pkg::OP_BIT_CLEAR) |->
      file_wdata == (prev_pin & ~(8'h01 << prev_instr[9:7])))
    else $error("port clear not from pins");

  chk_latch_source: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && !prev_port && prev_op == and_bit_pkg::OP_BIT_SET) |->
      file_wdata == (prev_latch | (8'h01 << prev_instr[9:7])))
    else $error("latch not used for non-port register");

  chk_prescaler_on_write: assert property (@(posedge clock) disable iff (rst)
    (prev_ok && prev_presc && prev_instr[6:0] == and_bit_pkg::TIMER_ZERO_COUNT_ADDR
      && (prev_op == and_bit_pkg::OP_BIT_CLEAR || prev_op == and_bit_pkg::OP_BIT_SET
      || (prev_op == and_bit_pkg::OP_AND_FILE && prev_instr[7]))) |-> prescaler_clear)
    else $error("prescaler clear missing on timer write");

endmodule // and_bit_exec

// ===== sim/tb.sv
/*
  Self-checking bench for the AND and bit set/clear datapath.
  Assumes and_bit_exec and and_bit_pkg are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] pin_rdata = 8'h00;
  logic file_is_port = 1'b0;
  logic prescaler_on_timer = 1'b0;
  logic [7:0] acc;
  logic zero_flag;
  logic file_we;
  logic [6:0] file_waddr;
  logic [7:0] file_wdata;
  logic prescaler_clear;
  logic done;
  int error_cnt = 0;
  int total_checks = 0;

  always #25 clock = ~clock;

  and_bit_exec dut (.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .pin_rdata(pin_rdata), .file_is_port(file_is_port),
    .prescaler_on_timer(prescaler_on_timer), .acc(acc), .zero_flag(zero_flag),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .prescaler_clear(prescaler_clear), .done(done));

  // ----------------------------------------------------------------
  // Compare and drive helpers
  // ----------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp, input string what);
    check8({7'h00, got}, {7'h00, exp}, what);
  endtask

  // Called at a falling edge; outputs are judged one full cycle later
  // Valid stays up until the next call or reset, so words run back to back
  task automatic run_op(input logic valid, input logic [13:0] word, input logic [7:0] latch,
                        input logic [7:0] pins, input logic port, input logic presc);
    instr_valid = valid;
    instr = word;
    file_rdata = latch;
    pin_rdata = pins;
    file_is_port = port;
    prescaler_on_timer = presc;
    @(posedge clock);
    @(negedge clock);
  endtask

  // Also used mid-run to bring the accumulator and zero flag back to their reset values
  task automatic do_reset();
    rst = 1'b1;
    instr_valid = 1'b0;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    check8(acc, 8'h00, "reset acc");
    check1(zero_flag, 1'b0, "reset zero");
    check1(done, 1'b0, "reset done");
    check1(file_we, 1'b0, "reset we");
    check1(prescaler_clear, 1'b0, "reset presc");
    @(negedge clock);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_bits();
    for (int b = 0; b < 8; b++) begin
      run_op(1'b1, {4'h4, 3'(b), 7'h10}, 8'hFF, 8'h00, 1'b0, 1'b0);
      check1(file_we, 1'b1, "clear we");
      check8({1'b0, file_waddr}, 8'h10, "clear addr");
      check8(file_wdata, ~(8'h01 << b), "clear data");
      check1(zero_flag, 1'b0, "clear zero");
      run_op(1'b1, {4'h5, 3'(b), 7'h7F}, 8'h00, 8'hFF, 1'b0, 1'b0);
      check8(file_wdata, 8'h01 << b, "set data");
      check8({1'b0, file_waddr}, 8'h7F, "set addr");
      check1(done, 1'b1, "set done");
    end
    $display("test bits done");
  endtask

  task automatic test_port_and_timer();
    run_op(1'b1, {4'h5, 3'h7, 7'h06}, 8'hF0, 8'h0F, 1'b1, 1'b0);
    check8(file_wdata, 8'h8F, "port data");
    run_op(1'b1, {4'h4, 3'h0, 7'h06}, 8'hFF, 8'h0F, 1'b1, 1'b0);
    check8(file_wdata, 8'h0E, "port clear data");
    run_op(1'b1, {4'h5, 3'h0, 7'h01}, 8'h40, 8'h00, 1'b0, 1'b1);
    check8(file_wdata, 8'h41, "timer set data");
    check1(prescaler_clear, 1'b1, "presc on set");
    run_op(1'b1, {4'h4, 3'h7, 7'h01}, 8'hC7, 8'h00, 1'b0, 1'b1);
    check8(file_wdata, 8'h47, "timer data");
    check1(prescaler_clear, 1'b1, "presc fires");
    run_op(1'b1, {4'h4, 3'h7, 7'h01}, 8'hC7, 8'h00, 1'b0, 1'b0);
    check1(prescaler_clear, 1'b0, "presc unassigned");
    run_op(1'b1, {4'h4, 3'h7, 7'h02}, 8'hC7, 8'h00, 1'b0, 1'b1);
    check1(prescaler_clear, 1'b0, "presc other addr");
    $display("test port and timer done");
  endtask

  task automatic test_literal_and_ignored();
    run_op(1'b1, {6'h39, 8'h5F}, 8'hFF, 8'hFF, 1'b0, 1'b0);
    check8(acc, 8'h00, "literal acc");
    check1(zero_flag, 1'b1, "literal zero");
    check1(file_we, 1'b0, "literal no write");
    check1(done, 1'b1, "literal done");
    run_op(1'b1, {4'h5, 3'h0, 7'h20}, 8'h00, 8'h00, 1'b0, 1'b0);
    check1(zero_flag, 1'b1, "set keeps zero");
    run_op(1'b1, 14'h3A00, 8'h00, 8'h00, 1'b0, 1'b0);
    check1(done, 1'b0, "unsupported done");
    check1(file_we, 1'b0, "unsupported we");
    run_op(1'b0, {4'h5, 3'h0, 7'h20}, 8'h00, 8'h00, 1'b0, 1'b0);
    check1(file_we, 1'b0, "invalid we");
    $display("test literal done");
  endtask

  task automatic test_file_and();
    do_reset();
    run_op(1'b1, {6'h05, 1'b0, 7'h04}, 8'hC2, 8'h00, 1'b0, 1'b1);
    check1(file_we, 1'b0, "and d0 no write");
    check8(acc, 8'h00, "and d0 acc");
    check1(zero_flag, 1'b1, "and d0 zero");
    do_reset();
    run_op(1'b1, {6'h05, 1'b1, 7'h01}, 8'hC2, 8'h00, 1'b0, 1'b1);
    check1(file_we, 1'b1, "and d1 write");
    check8({1'b0, file_waddr}, 8'h01, "and d1 addr");
    check8(file_wdata, 8'h00, "and d1 data");
    check1(zero_flag, 1'b1, "and d1 zero");
    check1(prescaler_clear, 1'b1, "and d1 presc");
    $display("test file and done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    test_bits();
    test_port_and_timer();
    test_literal_and_ignored();
    test_file_and();
    end_of_test();
  end

  initial begin
    #(2000 * 50);
    error_cnt++;
    end_of_test();
  end
endmodule // tb
